// ===== dtp_core_model.sv
// core-side bus model driving the timer register port
`timescale 1ns/1ps
module dtp_core_model
	import dtp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic [7:0] rdata_i,
	output dtp_bus_type bus_o
);
	initial begin
		bus_o = '0;
	end
	// ----------------------------------------
	// single cycles
	// ----------------------------------------
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk_i);
		bus_o <= '0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk_i);
		bus_o <= '0;
		#1;
		d = rdata_i;
	endtask
	// ----------------------------------------
	// timer b word access
	// ----------------------------------------
	// high first so the low write loads all sixteen bits at once
	task automatic wr16(input logic [15:0] v);
		wr(ADDR_TB_HIGH, v[15:8]);
		wr(ADDR_TB_LOW, v[7:0]);
	endtask
	// low first freezes the high byte in the pipe
	task automatic rd16(output logic [15:0] v);
		rd(ADDR_TB_LOW, v[7:0]);
		rd(ADDR_TB_HIGH, v[15:8]);
	endtask
endmodule

// ===== dtp_pkg.sv
// constants, types and register map of the dual timer block
package dtp_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [4:0] ADDR_TA_DATA = 5'h08;
	localparam logic [4:0] ADDR_TA_CTRL = 5'h09;
	localparam logic [4:0] ADDR_TB_HIGH = 5'h0B;
	localparam logic [4:0] ADDR_TB_LOW = 5'h0C;
	localparam logic [4:0] ADDR_TB_CTRL = 5'h0D;
	localparam logic [4:0] ADDR_MISC = 5'h0F;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int IRQ_FLAG_BIT = 7;
	localparam int SWAP_BIT = 1;
	localparam int PRE2_CLR_BIT = 2;
	localparam int PRE1_CLR_BIT = 3;
	localparam int WD_MASK_BIT = 4;
	localparam int WD_FLAG_BIT = 5;
	localparam int EXT2_MASK_BIT = 6;
	localparam int EXT2_FLAG_BIT = 7;
	// ----------------------------------------
	// widths and counts
	// ----------------------------------------
	localparam int PRE1_WIDTH = 7;
	localparam int PRE1_RATIO_W = 3;
	localparam int PRE2_WIDTH = 15;
	localparam int PRE2_RATIO_W = 4;
	localparam logic [11:0] WD_PERIOD = 12'hFFF;
	localparam logic [11:0] WD_LAST = 12'h001;
	localparam logic [7:0] TA_LAST = 8'h01;
	localparam logic [15:0] TB_LAST = 16'h0001;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {SRC_INTERNAL, SRC_GATED, SRC_OFF, SRC_EDGE} dtp_src_type;
	typedef struct packed {
		logic irq_flag;
		logic irq_mask;
		logic ext_select;
		logic ext_enable;
		logic load_mode;
		logic [2:0] ratio;
	} dtp_ctla_type;
	typedef struct packed {
		logic irq_flag;
		logic irq_mask;
		logic ext_select;
		logic ext_enable;
		logic [3:0] ratio;
	} dtp_ctlb_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} dtp_bus_type;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] TA_RESET = 8'hFF;
	localparam logic [15:0] TB_RESET = 16'hFFFF;
	localparam logic [6:0] PRE1_RESET = 7'h7F;
	localparam logic [14:0] PRE2_RESET = 15'h7FFF;
	localparam dtp_ctla_type CTLA_RESET = 8'h40;
	localparam dtp_ctlb_type CTLB_RESET = 8'h50;
	localparam logic SWAP_RESET = 1'b0;
	localparam logic WD_MASK_RESET = 1'b1;
endpackage

// ===== dtp_timer.sv
// dual timer with two prescalers and watchdog
// Operation
// RQ1: mode clear: data write loads modulus latch and counter together
// RQ2: mode set: latch loads timer A on rising edge of gated ext2 flag
// RQ3: timer A reloads from latch on reaching zero; zero load gives 256
// RQ4: reads never disturb timer A; counter and latch reset to FF
// RQ5: software avoids loading 01 with a divide-by-one prescaler
// RQ6: timer A zero sets sticky flag; mask set at reset blocks request
// RQ7: prescaler 1 source: internal, gated pin a, none, pin a edges
// RQ8: output pin contributes port data bit, input pin its level
// RQ9: three-bit ratio field picks divide by 1 to 128, reset clear
// RQ10: low byte read captures high byte into latch read later
// RQ11: low byte write loads counter with latch as high byte
// RQ12: high byte write updates only the latch
// RQ13: software reads low then high, writes high then low
// RQ14: timer B resets all ones, counts down per tick
// RQ15: timer B zero sets sticky flag; mask set at reset blocks request
// RQ16: each timer B zero yields a one-cycle overflow pulse
// RQ17: prescaler 2 source same encoding on pin b; enable set at reset
// RQ18: four-bit ratio field picks divide by 1 to 32768, reset clear
// RQ19: prescaler 1 is seven bits, presets on reset or clear write
// RQ20: prescaler 2 is fifteen bits, presets on reset or clear write
// RQ21: a tap of ratio N gives one tick every N source events
// RQ22: watchdog counts 4095 internal cycles then sets its flag
// RQ23: writing inverse flag presets watchdog; reset sets mask
// RQ24: flag set with mask clear drives the reset line low
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module dtp_prescaler
	import dtp_pkg::*;
#(
	parameter int WIDTH = PRE1_WIDTH,
	parameter int RATIO_W = PRE1_RATIO_W,
	parameter logic [WIDTH-1:0] PRESET = PRE1_RESET
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic clear_i,
	input wire dtp_src_type src_i,
	input wire logic gate_i,
	input wire logic rise_i,
	input wire logic [RATIO_W-1:0] ratio_i,
	output logic tick_o
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;
	logic [WIDTH-1:0] tap_mask;
	logic tick_next;
	logic event_hit;

	if (WIDTH != 2 ** RATIO_W - 1) begin
		$error("prescaler width must equal 2**RATIO_W - 1");
	end

	always_comb begin
		unique case (src_i) // see RQ7, RQ17
			SRC_INTERNAL: event_hit = 1'b1;
			SRC_GATED: event_hit = gate_i;
			SRC_OFF: event_hit = 1'b0;
			SRC_EDGE: event_hit = rise_i;
		endcase
		for (int i = 0; i < WIDTH; i++) begin
			tap_mask[i] = (i < int'(ratio_i)); // see RQ9, RQ18
		end
		// low k bits all zero once per 2**k events
		tick_next = event_hit && !clear_i && ((cnt_reg & tap_mask) == '0); // see RQ21
		cnt_next = cnt_reg;
		if (clear_i) begin
			cnt_next = PRESET; // see RQ19, RQ20
		end else if (event_hit) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			cnt_reg <= PRESET;
			tick_o <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_o <= tick_next;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	property p_pre_clear;
		clear_i |=> cnt_reg == PRESET && !tick_o;
	endproperty
	a_pre_clear: assert property (p_pre_clear) else $error("prescaler not preset"); // see RQ19

	property p_pre_tap;
		tick_o |-> $past(event_hit) && ($past(cnt_reg) & $past(tap_mask)) == '0;
	endproperty
	a_pre_tap: assert property (p_pre_tap) else $error("prescaler tick off tap"); // see RQ21
endmodule

module dtp_timer
	import dtp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire dtp_bus_type bus_i,
	output logic [7:0] rdata_o,
	input wire logic [1:0] event_pin_i,
	input wire logic [1:0] event_dir_i,
	input wire logic [1:0] event_data_i,
	input wire logic ext2_irq_flag_i,
	input wire logic ext2_irq_mask_i,
	output logic a_irq_req_o,
	output logic b_irq_req_o,
	output logic b_overflow_o,
	output logic wd_reset_n_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg, src_prev_reg;
	logic [1:0] pin_lvl_next, pin_src, pin_rise;
	logic ext2_prev_reg;
	logic ext2_rise;
	logic [7:0] ta_cnt_reg, ta_cnt_next, ta_latch_reg, ta_latch_next;
	logic [15:0] tb_cnt_reg, tb_cnt_next;
	logic [7:0] tb_pipe_reg, tb_pipe_next;
	dtp_ctla_type ctla_reg, ctla_next;
	dtp_ctlb_type ctlb_reg, ctlb_next;
	logic swap_reg, swap_next, wd_mask_reg, wd_mask_next;
	logic wd_flag_reg, wd_flag_next;
	logic [11:0] wd_cnt_reg, wd_cnt_next;
	logic [7:0] rdata_next;
	logic a_irq_next, b_irq_next, b_ovf_next, wd_rst_n_next;
	logic wr_ta, wr_ctla, wr_tbh, wr_tbl, wr_ctlb, wr_misc, rd_tbl;
	logic p1_tick, p2_tick, a_tick, b_tick;
	logic ta_zero, tb_zero, ta_ext_load, wd_timeout, wd_abort;

	// ----------------------------------------
	// pin conditioning
	// ----------------------------------------
	always_comb begin
		// a level counts once the second and third stages agree
		pin_lvl_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
			| (pin_lvl_reg & (pin_s2_reg ^ pin_s3_reg));
		pin_src = (event_dir_i & event_data_i) | (~event_dir_i & pin_lvl_reg); // see RQ8
		pin_rise = pin_src & ~src_prev_reg;
		ext2_rise = ext2_irq_flag_i && ext2_irq_mask_i && !ext2_prev_reg;
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	always_comb begin
		wr_ta = bus_i.wr && bus_i.addr == ADDR_TA_DATA;
		wr_ctla = bus_i.wr && bus_i.addr == ADDR_TA_CTRL;
		wr_tbh = bus_i.wr && bus_i.addr == ADDR_TB_HIGH;
		wr_tbl = bus_i.wr && bus_i.addr == ADDR_TB_LOW;
		wr_ctlb = bus_i.wr && bus_i.addr == ADDR_TB_CTRL;
		wr_misc = bus_i.wr && bus_i.addr == ADDR_MISC;
		rd_tbl = bus_i.rd && bus_i.addr == ADDR_TB_LOW;
	end

	// ----------------------------------------
	// prescalers
	// ----------------------------------------
	dtp_prescaler #(
		.WIDTH(PRE1_WIDTH),
		.RATIO_W(PRE1_RATIO_W),
		.PRESET(PRE1_RESET)
	) u_pre1 (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.clear_i(wr_misc && bus_i.wdata[PRE1_CLR_BIT]), // see RQ19
		.src_i(dtp_src_type'({ctla_reg.ext_select, ctla_reg.ext_enable})), // see RQ7
		.gate_i(pin_src[0]),
		.rise_i(pin_rise[0]),
		.ratio_i(ctla_reg.ratio),
		.tick_o(p1_tick)
	);

	dtp_prescaler #(
		.WIDTH(PRE2_WIDTH),
		.RATIO_W(PRE2_RATIO_W),
		.PRESET(PRE2_RESET)
	) u_pre2 (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.clear_i(wr_misc && bus_i.wdata[PRE2_CLR_BIT]), // see RQ20
		.src_i(dtp_src_type'({ctlb_reg.ext_select, ctlb_reg.ext_enable})), // see RQ17
		.gate_i(pin_src[1]),
		.rise_i(pin_rise[1]),
		.ratio_i(ctlb_reg.ratio),
		.tick_o(p2_tick)
	);

	// ----------------------------------------
	// timers and watchdog
	// ----------------------------------------
	always_comb begin
		a_tick = swap_reg ? p2_tick : p1_tick; // see RQ19, RQ20
		b_tick = swap_reg ? p1_tick : p2_tick;
		ta_ext_load = ext2_rise && ctla_reg.load_mode; // see RQ2
		// timer A: reaching zero reloads at once, so zero is held only after a load of 00
		ta_zero = a_tick && ta_cnt_reg == TA_LAST;
		ta_cnt_next = ta_cnt_reg;
		ta_latch_next = ta_latch_reg;
		if (ta_zero) begin
			ta_cnt_next = ta_latch_reg; // see RQ3
		end else if (a_tick) begin
			ta_cnt_next = ta_cnt_reg - 8'h01;
		end
		if (wr_ta) begin
			ta_latch_next = bus_i.wdata;
			if (!ctla_reg.load_mode) begin
				ta_cnt_next = bus_i.wdata; // see RQ1
			end
		end
		if (ta_ext_load) begin
			ta_cnt_next = ta_latch_reg; // see RQ2
		end
		ctla_next = ctla_reg;
		if (wr_ctla) begin
			ctla_next = dtp_ctla_type'(bus_i.wdata);
		end
		// set wins over a same-cycle clear
		ctla_next.irq_flag = ta_zero
			|| (ctla_reg.irq_flag && !(wr_ctla && !bus_i.wdata[IRQ_FLAG_BIT])); // see RQ6
		a_irq_next = ctla_next.irq_flag && !ctla_next.irq_mask; // see RQ6

		// timer B: a low-byte write beats a same-cycle tick
		tb_zero = b_tick && tb_cnt_reg == TB_LAST && !wr_tbl;
		tb_cnt_next = tb_cnt_reg;
		tb_pipe_next = tb_pipe_reg;
		if (b_tick) begin
			tb_cnt_next = tb_cnt_reg - 16'h0001; // see RQ14
		end
		if (rd_tbl) begin
			tb_pipe_next = tb_cnt_reg[15:8]; // see RQ10
		end
		if (wr_tbh) begin
			tb_pipe_next = bus_i.wdata; // see RQ12
		end
		if (wr_tbl) begin
			tb_cnt_next = {tb_pipe_reg, bus_i.wdata}; // see RQ11
		end
		ctlb_next = ctlb_reg;
		if (wr_ctlb) begin
			ctlb_next = dtp_ctlb_type'(bus_i.wdata);
		end
		ctlb_next.irq_flag = tb_zero
			|| (ctlb_reg.irq_flag && !(wr_ctlb && !bus_i.wdata[IRQ_FLAG_BIT])); // see RQ15
		b_irq_next = ctlb_next.irq_flag && !ctlb_next.irq_mask; // see RQ15
		b_ovf_next = tb_zero; // see RQ16

		// miscellaneous control and watchdog
		swap_next = wr_misc ? bus_i.wdata[SWAP_BIT] : swap_reg;
		wd_mask_next = wr_misc ? bus_i.wdata[WD_MASK_BIT] : wd_mask_reg;
		wd_timeout = wd_cnt_reg == WD_LAST; // see RQ22
		wd_abort = wr_misc && (bus_i.wdata[WD_FLAG_BIT] != wd_flag_reg); // see RQ23
		wd_cnt_next = (wd_timeout || wd_abort) ? WD_PERIOD : wd_cnt_reg - 12'h001;
		wd_flag_next = wd_timeout
			|| (wd_flag_reg && !(wr_misc && !bus_i.wdata[WD_FLAG_BIT])); // see RQ22
		wd_rst_n_next = !(wd_flag_next && !wd_mask_next); // see RQ24

		// read data; only the low-byte read has a side effect
		rdata_next = 8'h00;
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				ADDR_TA_DATA: rdata_next = ta_cnt_reg; // see RQ4
				ADDR_TA_CTRL: rdata_next = ctla_reg;
				ADDR_TB_HIGH: rdata_next = tb_pipe_reg; // see RQ10
				ADDR_TB_LOW: rdata_next = tb_cnt_reg[7:0];
				ADDR_TB_CTRL: rdata_next = ctlb_reg;
				ADDR_MISC: rdata_next = {ext2_irq_flag_i, ext2_irq_mask_i, wd_flag_reg,
					wd_mask_reg, 2'b00, swap_reg, 1'b0};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			pin_s1_reg <= 2'h0;
			pin_s2_reg <= 2'h0;
			pin_s3_reg <= 2'h0;
			pin_lvl_reg <= 2'h0;
			src_prev_reg <= 2'h0;
			ext2_prev_reg <= 1'b0;
			ta_cnt_reg <= TA_RESET; // see RQ4
			ta_latch_reg <= TA_RESET;
			tb_cnt_reg <= TB_RESET; // see RQ14
			tb_pipe_reg <= TB_RESET[15:8];
			ctla_reg <= CTLA_RESET; // see RQ6, RQ7, RQ9
			ctlb_reg <= CTLB_RESET; // see RQ15, RQ17, RQ18
			swap_reg <= SWAP_RESET;
			wd_mask_reg <= WD_MASK_RESET; // see RQ23
			wd_flag_reg <= 1'b0;
			wd_cnt_reg <= WD_PERIOD;
			rdata_o <= 8'h00;
			a_irq_req_o <= 1'b0;
			b_irq_req_o <= 1'b0;
			b_overflow_o <= 1'b0;
			wd_reset_n_o <= 1'b1;
		end else begin
			pin_s1_reg <= event_pin_i;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_lvl_reg <= pin_lvl_next;
			src_prev_reg <= pin_src;
			ext2_prev_reg <= ext2_irq_flag_i && ext2_irq_mask_i;
			ta_cnt_reg <= ta_cnt_next;
			ta_latch_reg <= ta_latch_next;
			tb_cnt_reg <= tb_cnt_next;
			tb_pipe_reg <= tb_pipe_next;
			ctla_reg <= ctla_next;
			ctlb_reg <= ctlb_next;
			swap_reg <= swap_next;
			wd_mask_reg <= wd_mask_next;
			wd_flag_reg <= wd_flag_next;
			wd_cnt_reg <= wd_cnt_next;
			rdata_o <= rdata_next;
			a_irq_req_o <= a_irq_next;
			b_irq_req_o <= b_irq_next;
			b_overflow_o <= b_ovf_next;
			wd_reset_n_o <= wd_rst_n_next;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	property p_direct_load;
		wr_ta && !ctla_reg.load_mode && !ta_ext_load
			|=> ta_cnt_reg == $past(bus_i.wdata) && ta_latch_reg == $past(bus_i.wdata);
	endproperty
	a_direct_load: assert property (p_direct_load) else $error("direct load lost"); // see RQ1

	property p_ext_load;
		ta_ext_load |=> ta_cnt_reg == $past(ta_latch_reg);
	endproperty
	a_ext_load: assert property (p_ext_load) else $error("ext2 load lost"); // see RQ2

	property p_mode_write;
		wr_ta && ctla_reg.load_mode && !a_tick && !ta_ext_load |=> $stable(ta_cnt_reg);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("write hit counter"); // see RQ2

	property p_reload;
		ta_zero && !wr_ta && !ta_ext_load
			|=> ta_cnt_reg == $past(ta_latch_reg) && ctla_reg.irq_flag;
	endproperty
	a_reload: assert property (p_reload) else $error("timer A reload missed"); // see RQ3

	property p_read_a;
		bus_i.rd && !a_tick && !wr_ta && !ta_ext_load |=> $stable(ta_cnt_reg);
	endproperty
	a_read_a: assert property (p_read_a) else $error("read disturbed timer A"); // see RQ4

	property p_a_mask;
		ctla_reg.irq_mask && !wr_ctla |=> !a_irq_req_o;
	endproperty
	a_a_mask: assert property (p_a_mask) else $error("masked request seen"); // see RQ6

	property p_pipe;
		rd_tbl |=> tb_pipe_reg == $past(tb_cnt_reg[15:8]) && rdata_o == $past(tb_cnt_reg[7:0]);
	endproperty
	a_pipe: assert property (p_pipe) else $error("pipeline capture wrong"); // see RQ10

	property p_low_write;
		wr_tbl |=> tb_cnt_reg == {$past(tb_pipe_reg), $past(bus_i.wdata)};
	endproperty
	a_low_write: assert property (p_low_write) else $error("16-bit load wrong"); // see RQ11

	property p_high_write;
		wr_tbh && !b_tick |=> $stable(tb_cnt_reg[15:8]) && tb_pipe_reg == $past(bus_i.wdata);
	endproperty
	a_high_write: assert property (p_high_write) else $error("high write hit counter"); // see RQ12

	property p_overflow;
		b_overflow_o |-> tb_cnt_reg == 16'h0000 && ctlb_reg.irq_flag ##1 !b_overflow_o;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow pulse wrong"); // see RQ16

	property p_wd_abort;
		wd_abort && !wd_timeout |=> wd_cnt_reg == WD_PERIOD ##1 wd_cnt_reg == WD_PERIOD - 12'h001;
	endproperty
	a_wd_abort: assert property (p_wd_abort) else $error("watchdog not preset"); // see RQ23

	property p_wd_reset;
		wd_timeout && !wd_mask_reg && !wr_misc |=> wd_flag_reg && !wd_reset_n_o;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset missing"); // see RQ24

	c_zero_load: cover property (wr_ta && bus_i.wdata == 8'h00 ##[1:300] ta_zero);
	c_b_overflow: cover property (wr_tbl ##[1:300] b_overflow_o);
	c_wd_timeout: cover property (wd_timeout && !wd_mask_reg);
	c_swap: cover property (swap_reg && a_tick);
endmodule

// ===== tb_top.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ps
module tb_top
	import dtp_pkg::*;
;
	logic sys_clk_i;
	logic rstn_i;
	dtp_bus_type bus;
	logic [7:0] rdata;
	logic [7:0] d;
	logic [7:0] v;
	logic [7:0] u;
	logic [15:0] w16;
	logic [1:0] pin;
	logic [1:0] dir;
	logic [1:0] pdata;
	logic ext2_flag;
	logic ext2_mask;
	logic a_req;
	logic b_req;
	logic b_ovf;
	logic wd_n;
	int num_errors;
	int compares;
	int cycles = 0;
	int ovf_cnt = 0;
	int ovf_base;
	int seed;
	int r;

	dtp_timer i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata),
		.event_pin_i(pin), .event_dir_i(dir), .event_data_i(pdata),
		.ext2_irq_flag_i(ext2_flag), .ext2_irq_mask_i(ext2_mask), .a_irq_req_o(a_req),
		.b_irq_req_o(b_req), .b_overflow_o(b_ovf), .wd_reset_n_o(wd_n));
	dtp_core_model i_core (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .bus_o(bus));

	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic wrap_up();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
		i_core.rd(a, d);
		check(16'(d), 16'(exp));
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// pin b is an output: its level is driven opposite to show it is ignored
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge sys_clk_i);
			if (idx == 0) pin[0] <= 1'b1;
			else {pdata[1], pin[1]} <= 2'b10;
			repeat (5) @(posedge sys_clk_i);
			if (idx == 0) pin[0] <= 1'b0;
			else {pdata[1], pin[1]} <= 2'b01;
			repeat (4) @(posedge sys_clk_i);
		end
		wait_n(8);
	endtask
	function automatic logic [7:0] ta_expect(input logic [7:0] start, input int ticks);
		return start - 8'(ticks);
	endfunction
	// timeout
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			wrap_up();
		end
	end
	// pulse counted mid-cycle, away from the edge that launches it
	always @(negedge sys_clk_i) begin
		if (b_ovf === 1'b1) begin
			ovf_cnt++;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h6d67;
		{num_errors, compares} = '0;
		rstn_i = 1'b0;
		{pin, pdata, ext2_flag, ext2_mask} = '0;
		dir = 2'b10;
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		chk_rd(ADDR_TA_CTRL, 8'h40);
		chk_rd(ADDR_TB_CTRL, 8'h50);
		i_core.rd16(w16);
		check(w16, 16'hFFFF);
		chk_rd(ADDR_MISC, 8'h10);
		chk_rd(5'h05, 8'h00);
		// direct and ext2 loading, source off
		v = 8'($random(seed));
		u = 8'($random(seed));
		i_core.wr(ADDR_TA_CTRL, 8'h60);
		i_core.wr(ADDR_TA_DATA, v);
		chk_rd(ADDR_TA_DATA, v);
		chk_rd(ADDR_TA_DATA, v);
		i_core.wr(ADDR_TA_CTRL, 8'h68);
		i_core.wr(ADDR_TA_DATA, u);
		chk_rd(ADDR_TA_DATA, v);
		ext2_flag <= 1'b1;
		wait_n(3);
		chk_rd(ADDR_TA_DATA, v);
		ext2_mask <= 1'b1;
		wait_n(3);
		chk_rd(ADDR_TA_DATA, u);
		{ext2_flag, ext2_mask} <= 2'b00;
		// reload, flag, mask; never 01 with divide by one
		i_core.wr(ADDR_TA_CTRL, 8'h70);
		i_core.wr(ADDR_TA_DATA, 8'h03);
		pulse(0, 3);
		chk_rd(ADDR_TA_DATA, 8'h03);
		chk_rd(ADDR_TA_CTRL, 8'hF0);
		check(16'(a_req), 16'h0000);
		i_core.wr(ADDR_TA_CTRL, 8'hB0);
		wait_n(2);
		check(16'(a_req), 16'h0001);
		i_core.wr(ADDR_TA_CTRL, 8'h30);
		i_core.wr(ADDR_TA_DATA, 8'h00);
		pulse(0, 255);
		chk_rd(ADDR_TA_CTRL, 8'h30);
		check(16'(a_req), 16'h0000);
		pulse(0, 1);
		chk_rd(ADDR_TA_CTRL, 8'hB0);
		// prescaler 1 taps
		for (int i = 0; i < 3; i++) begin
			r = $random(seed) & 7;
			i_core.wr(ADDR_TA_CTRL, 8'h30 | 8'(r));
			i_core.wr(ADDR_TA_DATA, 8'hF0);
			i_core.wr(ADDR_MISC, 8'h18);
			pulse(0, 4 << r);
			chk_rd(ADDR_TA_DATA, ta_expect(8'hF0, 4));
		end
		// timer b pipe latch
		i_core.wr(ADDR_TB_CTRL, 8'h60);
		i_core.wr16({v, u});
		i_core.rd16(w16);
		check(w16, {v, u});
		i_core.wr(ADDR_TB_HIGH, ~v);
		i_core.rd16(w16);
		check(w16, {v, u});
		// prescaler 2 taps from the port data bit
		for (int i = 0; i < 2; i++) begin
			r = $random(seed) & 7;
			i_core.wr(ADDR_TB_CTRL, 8'h30 | 8'(r));
			i_core.wr16(16'h1000);
			i_core.wr(ADDR_MISC, 8'h14);
			pulse(1, 4 << r);
			i_core.rd16(w16);
			check(w16, 16'h0FFC);
		end
		// timer b zero
		i_core.wr(ADDR_TB_CTRL, 8'h70);
		i_core.wr16(16'h0002);
		ovf_base = ovf_cnt;
		pulse(1, 2);
		check(16'(ovf_cnt - ovf_base), 16'h0001);
		i_core.rd16(w16);
		check(w16, 16'h0000);
		chk_rd(ADDR_TB_CTRL, 8'hF0);
		check(16'(b_req), 16'h0000);
		i_core.wr(ADDR_TB_CTRL, 8'hB0);
		wait_n(2);
		check(16'(b_req), 16'h0001);
		// swapped prescalers: pin a edges now clock timer B only
		i_core.wr(ADDR_TA_CTRL, 8'h30);
		i_core.wr16(16'h0010);
		i_core.wr(ADDR_TA_DATA, 8'h20);
		i_core.wr(ADDR_MISC, 8'h1E);
		pulse(0, 3);
		i_core.rd16(w16);
		check(w16, 16'h000D);
		chk_rd(ADDR_TA_DATA, 8'h20);
		// watchdog period, forced reset, abort
		i_core.rd(ADDR_MISC, d);
		i_core.wr(ADDR_MISC, {2'b00, ~d[5], 5'h10});
		repeat (4080) @(posedge sys_clk_i);
		chk_rd(ADDR_MISC, 8'h10);
		repeat (20) @(posedge sys_clk_i);
		chk_rd(ADDR_MISC, 8'h30);
		i_core.wr(ADDR_MISC, 8'h20);
		wait_n(3);
		check(16'(wd_n), 16'h0000);
		i_core.wr(ADDR_MISC, 8'h00);
		wait_n(3);
		check(16'(wd_n), 16'h0001);
		chk_rd(ADDR_MISC, 8'h00);
		// timeout with the mask already clear
		wait_n(4095);
		check(16'(wd_n), 16'h0000);
		chk_rd(ADDR_MISC, 8'h20);
		@(posedge sys_clk_i);
		rstn_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		chk_rd(ADDR_MISC, 8'h10);
		check(16'(wd_n), 16'h0001);
		wrap_up();
	end
endmodule
